//--- rtl/dio_defs.svh
// register offsets, field positions, reset values and timing figures for the discrete line block
`ifndef DISCRETE_LINE_DEFS_SVH
`define DISCRETE_LINE_DEFS_SVH
`define OFF_DIR      12'h000
`define OFF_LEVEL    12'h004
`define OFF_CTRL     12'h008
`define OFF_COMMIT   12'h00C
`define OFF_STATUS   12'h010
`define OFF_REQ      12'h014
`define OFF_ACTIVE   12'h018
`define CTRL_HOLD_EN 0
`define REQ_ERASE    0
`define REQ_FACTORY  1
`define DIR_RESET    4'h0
`define LEVEL_RESET  4'h0
`define HOLD_LINE    1
`define ERASE_SEC    3
`define FACTORY_SEC  10
`define CLK_HZ       50000000
`endif

//--- rtl/dio_pkg.sv
// types shared by the discrete line block
package discrete_pkg;
  typedef enum logic [1:0] {
    HOLD_IDLE,
    HOLD_LOW,
    HOLD_ERASED,
    HOLD_DONE
  } hold_state_t;
endpackage : discrete_pkg

//--- rtl/hold_timer.sv
// hold timer: measures how long the reset button line stays low
`timescale 1ns/1ps
`include "dio_defs.svh"
module hold_timer #(
  parameter int unsigned ERASE_CYCLES   = `ERASE_SEC * `CLK_HZ,
  parameter int unsigned FACTORY_CYCLES = `FACTORY_SEC * `CLK_HZ
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic enable,
  input  wire logic line_in,
  output logic      erase_pulse,
  output logic      factory_pulse
);
  import discrete_pkg::*;

  typedef struct packed {
    hold_state_t state;
    logic [31:0] count;
    logic        erase;
    logic        factory;
  } ht_state_t;

  ht_state_t st_ff;     // all registered state
  ht_state_t nxt_st;    // next state

  assign erase_pulse   = st_ff.erase;
  assign factory_pulse = st_ff.factory;

  // count cycles while low; any high level restarts from zero
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.erase   = 1'b0;
    nxt_st.factory = 1'b0;
    if (!enable || line_in) begin
      nxt_st.state = HOLD_IDLE;
      nxt_st.count = 32'h0000_0000;
    end else begin
      unique case (st_ff.state)
        HOLD_IDLE: begin
          nxt_st.state = HOLD_LOW;
          nxt_st.count = 32'h0000_0001;
        end
        HOLD_LOW: begin
          nxt_st.count = st_ff.count + 32'h0000_0001;
          if (nxt_st.count >= ERASE_CYCLES) begin
            nxt_st.erase = 1'b1;
            nxt_st.state = HOLD_ERASED;
          end
        end
        HOLD_ERASED: begin
          nxt_st.count = st_ff.count + 32'h0000_0001;
          if (nxt_st.count >= FACTORY_CYCLES) begin
            nxt_st.factory = 1'b1;
            nxt_st.state   = HOLD_DONE;
          end
        end
        HOLD_DONE: begin
          // one request per press; wait for release
          nxt_st.state = HOLD_DONE;
        end
      endcase
    end
  end

  // register the state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '{state: HOLD_IDLE, count: 32'h0000_0000, erase: 1'b0, factory: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : hold_timer

//--- rtl/discrete_io.sv
// four discrete lines with staged configuration, apb access and hold-to-reset button
`timescale 1ns/1ps
`include "dio_defs.svh"
// Function
// - each line has its own direction setting
// - input lines report the external switch level
// - output lines drive their configured level
// - level setting ignored while line is input
// - hold-to-reset forces line 1 input
// - line 1 low 3 s: erase request
// - line 1 low 10 s: factory request
// - hold-to-reset disabled after reset
// - settings take effect only on commit
module discrete_io #(
  parameter int unsigned LINES          = 4,
  parameter int unsigned ERASE_CYCLES   = `ERASE_SEC * `CLK_HZ,
  parameter int unsigned FACTORY_CYCLES = `FACTORY_SEC * `CLK_HZ
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [LINES-1:0] line_in,
  output logic      [LINES-1:0] line_out,
  output logic      [LINES-1:0] line_oe,
  output logic                  erase_req,
  output logic                  factory_req
);
  import discrete_pkg::*;

  // register map, one aligned 32-bit word each
  //   direction  staged, bit n = 1 makes line n an output
  //   level      staged, level driven by output lines
  //   control    staged, hold-to-reset enable in the low bit
  //   commit     write any value to copy the staged set to the lines
  //   status     read only, pin for inputs, driven level for outputs
  //   request    erase and factory flags, write ones to clear
  //   active     read only, effective direction and hold enable
  // offsets step by four bytes and paddr is compared in full, so no alias answers
  // staging lets software change several lines and the button mode together;
  // a half-written setup never reaches the pins

  // all state of the block except the button timer in one record; stage fields hold what software
  // wrote, act fields hold what the pins use
  typedef struct packed {
    logic [LINES-1:0] dir_stage;   // staged direction, 1 = output
    logic [LINES-1:0] lvl_stage;   // staged level
    logic             hold_stage;  // staged hold-to-reset enable
    logic [LINES-1:0] dir_act;     // committed direction
    logic [LINES-1:0] lvl_act;     // committed level
    logic             hold_act;    // committed hold-to-reset enable
    logic [LINES-1:0] line_out;    // registered pin level
    logic [LINES-1:0] line_oe;     // registered pin enable
    logic [31:0]      prdata;      // registered read data
    logic [1:0]       req;         // sticky erase / factory requests
  } io_state_t;

  io_state_t st_ff;      // all registered state except the button timer
  io_state_t nxt_st;     // next state
  logic      erase_p;    // one-cycle erase event from the timer
  logic      factory_p;  // one-cycle factory event from the timer
  logic      wr_en;      // write access phase
  logic      rd_en;      // read setup phase
  logic      mapped;     // address hits a register
  logic [LINES-1:0] eff_dir; // direction after the button override

  // zero wait state slave: every access ends in its first access cycle
  // read data are loaded at the end of the setup cycle, so they already stand
  // in the access cycle where the master takes them together with pready
  // writes land at the access edge; an unmapped address is flagged and dropped
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_en   = psel && penable && pwrite && mapped;
  assign rd_en   = psel && !penable && !pwrite && mapped;
  assign prdata  = st_ff.prdata;
  assign line_out    = st_ff.line_out;
  assign line_oe     = st_ff.line_oe;
  assign erase_req   = st_ff.req[`REQ_ERASE];
  assign factory_req = st_ff.req[`REQ_FACTORY];

  // address decode
  // only the seven word addresses answer; anything else raises pslverr
  always_comb begin
    unique case (paddr)
      `OFF_DIR, `OFF_LEVEL, `OFF_CTRL, `OFF_COMMIT,
      `OFF_STATUS, `OFF_REQ, `OFF_ACTIVE: mapped = 1'b1;
      default:                            mapped = 1'b0;
    endcase
  end

  // per-line effective direction; line 1 is forced to input by the button
  // one loop, so a wider port only needs a new LINES value
  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : g_dir
      if (g == `HOLD_LINE) begin : g_btn
        // the button line can drive only while the button function is off
        assign eff_dir[g] = st_ff.dir_act[g] && !st_ff.hold_act;
      end else begin : g_plain
        // every other line follows its own committed direction bit
        assign eff_dir[g] = st_ff.dir_act[g];
      end
    end
  endgenerate

  // the button timer looks only at the pin while the function is committed on
  // it restarts whenever the function is off, so switching it on never
  // inherits a count from a line that was low as an output
  // limitation: a bouncing switch also restarts the count, which suits a
  // press that must be held; a real pin wants a synchroniser in front
  hold_timer #(
    .ERASE_CYCLES   (ERASE_CYCLES),
    .FACTORY_CYCLES (FACTORY_CYCLES)
  ) u_hold (
    .pclk          (pclk),
    .presetn       (presetn),
    .enable        (st_ff.hold_act),
    .line_in       (line_in[`HOLD_LINE]),
    .erase_pulse   (erase_p),
    .factory_pulse (factory_p)
  );

  // register writes, commit, pins, read data and request flags
  // everything lands in one next-state copy, so a write and an event in the
  // same cycle are resolved in one place, by statement order
  always_comb begin
    // by default every field keeps its value
    nxt_st = st_ff;
    // pins: drive only output lines, level is meaningless for inputs
    // the pins follow the committed set one cycle after the commit edge
    nxt_st.line_oe  = eff_dir;
    // masking with the direction keeps an input's level off the pin
    nxt_st.line_out = st_ff.lvl_act & eff_dir;
    // writes in the access cycle
    if (wr_en) begin
      unique case (paddr)
        // staged direction, not yet on the pins
        `OFF_DIR: begin
          nxt_st.dir_stage = pwdata[LINES-1:0];
        end
        // staged level, used only by output lines
        `OFF_LEVEL: begin
          nxt_st.lvl_stage = pwdata[LINES-1:0];
        end
        // staged button enable
        `OFF_CTRL: begin
          nxt_st.hold_stage = pwdata[`CTRL_HOLD_EN];
        end
        `OFF_COMMIT: begin
          // staged values move to the lines only here; the data word is ignored
          nxt_st.dir_act  = st_ff.dir_stage;
          nxt_st.lvl_act  = st_ff.lvl_stage;
          nxt_st.hold_act = st_ff.hold_stage;
        end
        // writing ones to the request register clears those flags
        `OFF_REQ: begin
          nxt_st.req = st_ff.req & ~pwdata[`REQ_FACTORY:`REQ_ERASE];
        end
        default: begin
          // read-only registers ignore writes
        end
      endcase
    end
    // new events win over a clear in the same cycle, so a press is never lost
    if (erase_p) begin
      nxt_st.req[`REQ_ERASE] = 1'b1;
    end
    if (factory_p) begin
      nxt_st.req[`REQ_FACTORY] = 1'b1;
    end
    // reads in the setup cycle; prdata then stands through the access cycle
    if (rd_en) begin
      // unused upper bits read as zero
      nxt_st.prdata = 32'h0000_0000;
      unique case (paddr)
        `OFF_DIR:    nxt_st.prdata[LINES-1:0] = st_ff.dir_stage;
        `OFF_LEVEL:  nxt_st.prdata[LINES-1:0] = st_ff.lvl_stage;
        `OFF_CTRL:   nxt_st.prdata[`CTRL_HOLD_EN] = st_ff.hold_stage;
        // status shows the pin for inputs, the driven level for outputs
        `OFF_STATUS: nxt_st.prdata[LINES-1:0] =
                       (line_in & ~eff_dir) | (st_ff.lvl_act & eff_dir);
        // both request flags, set until software clears them
        `OFF_REQ:    nxt_st.prdata[`REQ_FACTORY:`REQ_ERASE] = st_ff.req;
        // effective direction shows the button override, not the staged value
        `OFF_ACTIVE: nxt_st.prdata[LINES:0] = {st_ff.hold_act, eff_dir};
        // commit reads as zero
        default:     nxt_st.prdata = 32'h0000_0000;
      endcase
    end
  end

  // register the state; button function comes up disabled
  // reset makes every line an input, so nothing is driven until software commits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '{dir_stage:  `DIR_RESET,
                 lvl_stage:  `LEVEL_RESET,
                 hold_stage: 1'b0,
                 dir_act:    `DIR_RESET,
                 lvl_act:    `LEVEL_RESET,
                 hold_act:   1'b0,
                 line_out:   '0,
                 line_oe:    '0,
                 prdata:     32'h0000_0000,
                 req:        2'b00};
    end else begin
      // one register for the whole record
      st_ff <= nxt_st;
    end
  end
endmodule : discrete_io

//--- verif/discrete_io_chk.sv
// port checker for the discrete line block
`timescale 1ns/1ps
`include "dio_defs.svh"
module discrete_io_chk #(
  parameter int unsigned LINES          = 4,
  parameter int unsigned ERASE_CYCLES   = 30,
  parameter int unsigned FACTORY_CYCLES = 100
) (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic             pready,
  input wire logic [LINES-1:0] line_in,
  input wire logic [LINES-1:0] line_out,
  input wire logic [LINES-1:0] line_oe,
  input wire logic             erase_req,
  input wire logic             factory_req
);
  int unsigned low_cnt;  // consecutive low samples on the button line
  logic        cmt;      // commit write accepted
  logic        clr0;     // erase flag clear
  logic        clr1;     // factory flag clear
  assign cmt  = psel && penable && pwrite && paddr == `OFF_COMMIT;
  assign clr0 = psel && penable && pwrite && paddr == `OFF_REQ && pwdata[0];
  assign clr1 = psel && penable && pwrite && paddr == `OFF_REQ && pwdata[1];
  // counts regardless of hold enable, so it only bounds the request from below
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_cnt <= 0;
    else low_cnt <= line_in[`HOLD_LINE] ? 0 : low_cnt + 1;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  out_idle_a: assert property ((line_out & ~line_oe) == 0)
    else $error("undriven line shows a level");
  pins_commit_a: assert property ($changed(line_oe) || $changed(line_out)
    |-> $past(cmt) || $past(cmt, 2)) else $error("pins moved without commit");
  reset_idle_a: assert property (!$past(presetn) |-> line_oe == 0 && !erase_req)
    else $error("lines not idle after reset");
  erase_time_a: assert property ($rose(erase_req)
    |-> low_cnt >= ERASE_CYCLES && !line_oe[`HOLD_LINE]) else $error("erase too early");
  factory_time_a: assert property ($rose(factory_req) |-> low_cnt >= FACTORY_CYCLES)
    else $error("factory too early");
  erase_keep_a: assert property ($fell(erase_req) |-> $past(clr0))
    else $error("erase flag dropped");
  factory_keep_a: assert property ($fell(factory_req) |-> $past(clr1))
    else $error("factory flag dropped");
  bus_ready_a: assert property (psel && penable |-> pready)
    else $error("no ready");
endmodule : discrete_io_chk
bind discrete_io discrete_io_chk #(.LINES(LINES), .ERASE_CYCLES(ERASE_CYCLES),
  .FACTORY_CYCLES(FACTORY_CYCLES)) chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .line_in(line_in), .line_out(line_out), .line_oe(line_oe), .erase_req(erase_req),
  .factory_req(factory_req));

//--- verif/line_switches.sv
// switches and loads on the four discrete lines
`timescale 1ns/1ps
module line_switches (
  input  wire logic [3:0] sw,        // switch levels chosen by the bench
  input  wire logic [3:0] line_out,  // levels the block drives
  input  wire logic [3:0] line_oe,   // high where the block drives
  output logic      [3:0] line_in    // level seen on each pin
);
  // a driven pin shows the block, an open one its switch; the bench holds the press length
  assign line_in = (line_oe & line_out) | (~line_oe & sw);
endmodule : line_switches

//--- verif/discrete_io_with_hold_reset_bench.sv
// self-checking bench for the discrete line block
`timescale 1ns/1ps
`include "dio_defs.svh"
module discrete_io_with_hold_reset_bench;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        pready, pslverr, erase_req, factory_req, err;
  logic [11:0] paddr  = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  sw     = 4'h7, line_in, line_out, line_oe;
  int          mismatches = 0, n_compared = 0;
  discrete_io #(.ERASE_CYCLES(30), .FACTORY_CYCLES(100)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_in(line_in),
    .line_out(line_out), .line_oe(line_oe), .erase_req(erase_req), .factory_req(factory_req));
  line_switches sws (.sw(sw), .line_out(line_out), .line_oe(line_oe), .line_in(line_in));
  initial forever #10 pclk = ~pclk;
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  // one apb transfer; response and read data are taken at the edge with pready high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin @(posedge pclk); n++; end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin mismatches++; report_and_stop; end
    err = pslverr;
    rd  = prdata;
    psel <= 1'h0; penable <= 1'h0;
    @(posedge pclk);
  endtask : apb
  // button press of n cycles, then released
  task automatic press(input int n);
    @(posedge pclk) sw[1] <= 1'h0;
    repeat (n) @(posedge pclk);
    sw[1] <= 1'h1;
    repeat (3) @(posedge pclk);
  endtask : press
  task automatic t_reset;
    apb(1'h0, `OFF_ACTIVE, 32'h0);
    chk("active", rd, 32'h0);
    chk("oe", line_oe, 4'h0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_dir;
    apb(1'h1, `OFF_DIR, 32'hA);
    apb(1'h1, `OFF_LEVEL, 32'h3);
    chk("staged oe", line_oe, 4'h0);
    apb(1'h1, `OFF_COMMIT, 32'h0);
    repeat (2) @(posedge pclk);
    chk("oe", line_oe, 4'hA);
    chk("out", line_out, 4'h2);
    chk("input ignores level", line_out[0], 1'h0);
    apb(1'h0, `OFF_STATUS, 32'h0);
    chk("status", rd, 32'h7);
    apb(1'h0, 12'h020, 32'h0);
    chk("unmapped", err, 1'h1);
    $display("t_dir done");
  endtask : t_dir
  task automatic t_hold;
    apb(1'h1, `OFF_DIR, 32'h2);
    apb(1'h1, `OFF_CTRL, 32'h1);
    apb(1'h1, `OFF_COMMIT, 32'h0);
    repeat (2) @(posedge pclk);
    chk("held in", line_oe, 4'h0);
    press(20);
    press(20);
    chk("short", erase_req, 1'h0);
    press(40);
    chk("erase", {factory_req, erase_req}, 2'h1);
    press(120);
    chk("factory", factory_req, 1'h1);
    apb(1'h1, `OFF_REQ, 32'h3);
    apb(1'h0, `OFF_REQ, 32'h0);
    chk("cleared", rd, 32'h0);
    $display("t_hold done");
  endtask : t_hold
  // reset in mid-run while the button function is on: it must come back off
  task automatic t_rst_mid;
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, `OFF_ACTIVE, 32'h0);
    chk("active after reset", rd, 32'h0);
    apb(1'h0, `OFF_CTRL, 32'h0);
    chk("staged hold after reset", rd, 32'h0);
    $display("t_rst_mid done");
  endtask : t_rst_mid
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    t_reset;
    t_dir;
    t_hold;
    t_rst_mid;
    report_and_stop;
  end
endmodule : discrete_io_with_hold_reset_bench
